/* File: src/swp_core.sv */
// Sector write protection: lock registers, range decode and gating.
// Function
// - Protected if either scheme protects.
// - One lock register per 64K sector.
// - Dedicated read and write lock commands.
// - Write-lock bit blocks program, erase, write.
// - Lock-down freezes lock bits until power-up.
// - Lock bits changeable while lock-down clear.
// - Protect size field and end select range.
// - Protect pin freezes status register.
// - Size code zero protects nothing.
// - End select 0 protects top sectors.
// - End select 1 protects bottom sectors.
// - Three array variants, boot sectors flagged.
// - Sector or frozen-status violation sets protection flag bit.
// - Upper eight address bits select sector.
`timescale 1ns/1ps
`default_nettype none
`include "swp_regs.svh"
module swp_core #(
	parameter int                 SECTORS = `SWP_SECTORS,   // Lock regs.
	parameter swp_pkg::swp_arch_e ARCH    = swp_pkg::SWP_ARCH_UNIFORM
) (
	input  wire logic                  clk,          // Device clock.
	input  wire logic                  nrst,         // Power-up reset.
	input  wire logic                  ce,           // Clock enable.
	input  wire logic                  cmd_valid,    // Command strobe.
	input  wire swp_pkg::swp_op_e      cmd_op,       // Operation.
	input  wire logic [23:0]           cmd_addr,     // Array address.
	input  wire logic [1:0]            cmd_lock_in,  // New lock bits.
	input  wire logic [5:0]            cmd_stat_in,  // New status bits.
	input  wire logic                  modify_permit_latch, // Permit.
	input  wire logic                  wp_n_pin,     // Protect pin.
	input  wire logic                  flag_clear,   // Clear flag.
	output logic                       done,         // Command done.
	output logic                       rejected,     // Was refused.
	output logic                       modify_start, // Start modify.
	output logic [1:0]                 lock_out,     // Read lock bits.
	output logic                       prot_flag,    // Protection flag.
	output logic [3:0]                 protect_size, // Size field.
	output logic                       range_end_select, // End select.
	output logic                       status_freeze_bit, // Freeze bit.
	output logic                       boot_sector   // Target in boot.
);
	// Two-flop reset release and pin synchroniser.
	logic       rst_s1_q, rst_s2_q;
	logic       wp_s1_q, wp_s2_q;
	logic       rst_n;

	// Lock storage: bit 0 write lock, bit 1 lock down.
	logic [1:0] lock_q [SECTORS];
	logic [1:0] lock_d [SECTORS];

	// Status bits: {freeze, end select, size[3:0]}.
	logic [5:0] stat_q, stat_d;

	// Registered outputs and their next values.
	logic       done_q, done_d;
	logic       rej_q, rej_d;
	logic       mod_q, mod_d;
	logic [1:0] lko_q, lko_d;
	logic       flag_q, flag_d;
	logic       boot_q, boot_d;

	// Decode helpers.
	swp_pkg::swp_sect_t sect;
	logic       range_hit;
	logic       locked_wr;
	logic       sector_prot;
	logic       stat_locked;
	logic       is_modify;
	logic [1:0] lock_cur;    // Lock bits of the addressed sector.

	// Reset is released through two flops to avoid a ragged release.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// The protect pin is asynchronous, so it passes two flops first.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
		end else if (ce) begin
			wp_s1_q <= wp_n_pin;
			wp_s2_q <= wp_s1_q;
		end
	end

	// Returns 1 when the sector is one of the boot sectors of ARCH.
	function automatic logic is_boot(input swp_pkg::swp_sect_t s);
		case (ARCH)
			swp_pkg::SWP_ARCH_BOTTOM: is_boot = (s < 8'(`SWP_BOOT_SECTS));
			swp_pkg::SWP_ARCH_TOP:
				is_boot = (s >= 8'(`SWP_SECTORS - `SWP_BOOT_SECTS));
			default:                  is_boot = 1'b0;
		endcase
	endfunction

	assign sect = cmd_addr[`SWP_SECT_LSB +: `SWP_SECT_W];

	// Range scheme decode lives in its own small module.
	swp_range u_range (
		.bp   (stat_q[3:0]),
		.tb   (stat_q[4]),
		.sect (sect),
		.hit  (range_hit)
	);

	assign locked_wr   = lock_q[sect][`SWP_LOCK_WL_BIT];
	assign lock_cur    = lock_q[sect];
	assign sector_prot = locked_wr | range_hit;
	// Freeze bit with the pin low makes the status read-only.
	assign stat_locked = stat_q[5] & ~wp_s2_q;
	assign is_modify   = (cmd_op == swp_pkg::SWP_OP_PROGRAM) ||
		(cmd_op == swp_pkg::SWP_OP_ERASE) ||
		(cmd_op == swp_pkg::SWP_OP_WRITE);

	// Next-state logic for the whole command path.
	always_comb begin
		lock_d = lock_q;
		stat_d = stat_q;
		done_d = 1'b0;
		rej_d  = 1'b0;
		mod_d  = 1'b0;
		lko_d  = lko_q;
		boot_d = boot_q;
		flag_d = flag_q & ~flag_clear;
		if (cmd_valid) begin
			done_d = 1'b1;
			boot_d = is_boot(sect);
			case (cmd_op)
				swp_pkg::SWP_OP_PROGRAM, swp_pkg::SWP_OP_ERASE,
				swp_pkg::SWP_OP_WRITE: begin
					// The permit latch is the host's duty; no permit, no cycle.
					if (!modify_permit_latch) begin
						rej_d = 1'b1;
					end else if (sector_prot) begin
						rej_d  = 1'b1;
						flag_d = 1'b1;
					end else begin
						mod_d = 1'b1;
					end
				end
				swp_pkg::SWP_OP_RD_LOCK: begin
					lko_d = lock_q[sect];
				end
				swp_pkg::SWP_OP_WR_LOCK: begin
					if (!modify_permit_latch) begin
						rej_d = 1'b1;
					end else if (lock_q[sect][`SWP_LOCK_LD_BIT]) begin
						rej_d = 1'b1;
					end else begin
						lock_d[sect] = cmd_lock_in;
					end
				end
				swp_pkg::SWP_OP_WR_STATUS: begin
					if (!modify_permit_latch) begin
						rej_d = 1'b1;
					end else if (stat_locked) begin
						rej_d  = 1'b1;
						flag_d = 1'b1;
					end else begin
						stat_d = cmd_stat_in;
					end
				end
				default: begin
					done_d = 1'b1;
				end
			endcase
		end
	end

	// Registers only; the flag set above beats a same-cycle clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < SECTORS; i++) begin
				lock_q[i] <= `SWP_LOCK_RST;
			end
			stat_q <= `SWP_STAT_RST;
			done_q <= 1'b0;
			rej_q  <= 1'b0;
			mod_q  <= 1'b0;
			lko_q  <= 2'h0;
			flag_q <= 1'b0;
			boot_q <= 1'b0;
		end else if (ce) begin
			lock_q <= lock_d;
			stat_q <= stat_d;
			done_q <= done_d;
			rej_q  <= rej_d;
			mod_q  <= mod_d;
			lko_q  <= lko_d;
			flag_q <= flag_d;
			boot_q <= boot_d;
		end
	end

	assign done              = done_q;
	assign rejected          = rej_q;
	assign modify_start      = mod_q;
	assign lock_out          = lko_q;
	assign prot_flag         = flag_q;
	assign protect_size      = stat_q[3:0];
	assign range_end_select  = stat_q[4];
	assign status_freeze_bit = stat_q[5];
	assign boot_sector       = boot_q;

	// Checks beside the logic they guard. They all run on the released
	// reset copy, so a ragged release can never fire one of them.

	// Lock scheme: a set write-lock bit stops every modify, a free sector
	// is modified, and lock-down holds the bits until the next power-up.
	AST_LOCK_BLOCKS: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && is_modify && locked_wr |=> rej_q && !mod_q)
		else $error("locked sector modified");
	AST_EITHER: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && is_modify && modify_permit_latch &&
		!sector_prot |=> mod_q)
		else $error("free sector not modified");
	AST_LOCKDOWN: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && cmd_op == swp_pkg::SWP_OP_WR_LOCK &&
		lock_cur[`SWP_LOCK_LD_BIT]
		|=> lock_q[$past(sect)] == $past(lock_cur))
		else $error("locked-down bits changed");
	AST_LOCK_WRITE: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && cmd_op == swp_pkg::SWP_OP_WR_LOCK &&
		modify_permit_latch && !lock_cur[`SWP_LOCK_LD_BIT]
		|=> lock_q[$past(sect)] == $past(cmd_lock_in))
		else $error("lock write lost");
	AST_READ_LOCK: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && cmd_op == swp_pkg::SWP_OP_RD_LOCK
		|=> lko_q == $past(lock_cur))
		else $error("bad lock read");
	// Without the permit latch nothing that modifies may proceed; the
	// host owns that latch, so the block checks it before its lock, range and freeze guards.
	AST_PERMIT: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && !modify_permit_latch &&
		(is_modify || cmd_op == swp_pkg::SWP_OP_WR_LOCK ||
		cmd_op == swp_pkg::SWP_OP_WR_STATUS) |=> rej_q && !mod_q)
		else $error("unpermitted op accepted");
	// Status register: frozen it keeps its value, free it takes writes.
	AST_STAT_FROZEN: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && stat_locked |=> $stable(stat_q))
		else $error("frozen status changed");
	AST_STAT_WRITE: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && cmd_op == swp_pkg::SWP_OP_WR_STATUS &&
		modify_permit_latch && !stat_locked
		|=> stat_q == $past(cmd_stat_in))
		else $error("status write lost");
	// Protection flag: raised by either kind of violation, then sticky.
	AST_FLAG: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && is_modify && modify_permit_latch &&
		sector_prot |=> flag_q)
		else $error("flag not set");
	AST_STAT_FLAG: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid && cmd_op == swp_pkg::SWP_OP_WR_STATUS &&
		modify_permit_latch && stat_locked |=> rej_q && flag_q)
		else $error("status violation not flagged");
	AST_FLAG_STICKY: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && flag_q && !flag_clear |=> flag_q)
		else $error("flag lost without clear");
	// Answer pulses: one per command, none without, never both kinds.
	AST_DONE: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid |=> done_q)
		else $error("command not answered");
	AST_IDLE: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && !cmd_valid |=> !done_q && !rej_q && !mod_q)
		else $error("pulse without command");
	AST_NO_CYCLE: assert property (
		@(posedge clk) disable iff (!rst_n)
		rej_q |-> !mod_q)
		else $error("rejected op started");
	// Range decode at its end points, for both ends of the array.
	AST_BP_ZERO: assert property (
		@(posedge clk) disable iff (!rst_n)
		stat_q[3:0] == `SWP_BP_NONE |-> !range_hit)
		else $error("zero code protects");
	AST_TOP_END: assert property (
		@(posedge clk) disable iff (!rst_n)
		!stat_q[4] && stat_q[3:0] == 4'h1
		|-> range_hit == (sect == 8'hFF))
		else $error("top range wrong");
	AST_TOP_HALF: assert property (
		@(posedge clk) disable iff (!rst_n)
		!stat_q[4] && stat_q[3:0] == `SWP_BP_MAXRANGE
		|-> range_hit == sect[7])
		else $error("top half wrong");
	AST_BOT_END: assert property (
		@(posedge clk) disable iff (!rst_n)
		stat_q[4] && stat_q[3:0] == `SWP_BP_MAXRANGE
		|-> range_hit == !sect[7])
		else $error("bottom range wrong");
	AST_ALL_CODE: assert property (
		@(posedge clk) disable iff (!rst_n)
		stat_q[3:0] > `SWP_BP_MAXRANGE |-> range_hit)
		else $error("large code leaves a gap");
	// The boot flag follows the sector of the last command.
	AST_BOOT: assert property (
		@(posedge clk) disable iff (!rst_n)
		ce && cmd_valid |=> boot_q ==
		((ARCH == swp_pkg::SWP_ARCH_BOTTOM) ? ($past(sect) < 8'h08) :
		(ARCH == swp_pkg::SWP_ARCH_TOP) ? ($past(sect) > 8'hF7) : 1'b0))
		else $error("boot flag wrong");
endmodule
`default_nettype wire

/* File: shared/swp_regs.svh */
// Constants for the sector write protection block.
`ifndef SWP_REGS_SVH
`define SWP_REGS_SVH
`define SWP_SECTORS      256
`define SWP_SECT_W       8
`define SWP_ADDR_W       24
`define SWP_SECT_LSB     16
`define SWP_BP_W         4
`define SWP_BP_NONE      4'h0
`define SWP_BP_MAXRANGE  4'h8
`define SWP_LOCK_WL_BIT  0
`define SWP_LOCK_LD_BIT  1
`define SWP_LOCK_RST     2'h0
`define SWP_BOOT_SECTS   8
`define SWP_BOOT_SUBS    16
`define SWP_STAT_RST     6'h00
`endif

/* File: shared/swp_pkg.sv */
// Types shared by the sector write protection block.
package swp_pkg;
	// Operation requested by the host command decoder.
	typedef enum logic [2:0] {
		SWP_OP_NONE,
		SWP_OP_PROGRAM,
		SWP_OP_ERASE,
		SWP_OP_WRITE,
		SWP_OP_RD_LOCK,
		SWP_OP_WR_LOCK,
		SWP_OP_WR_STATUS
	} swp_op_e;
	// Array build variant.
	typedef enum logic [1:0] {
		SWP_ARCH_UNIFORM,
		SWP_ARCH_BOTTOM,
		SWP_ARCH_TOP
	} swp_arch_e;
	// Sector number type.
	typedef logic [7:0] swp_sect_t;
endpackage

/* File: src/swp_range.sv */
// Decoder of the status register protected range for one sector.
`timescale 1ns/1ps
`default_nettype none
`include "swp_regs.svh"
module swp_range (
	input  wire logic [3:0] bp,      // Protect size field.
	input  wire logic       tb,      // Range end select.
	input  wire logic [7:0] sect,    // Sector under test.
	output logic            hit      // Sector lies in range.
);
	logic [8:0] span;  // Number of protected sectors.

	// Code n in 1..8 covers 2**(n-1) sectors; larger codes cover all.
	always_comb begin
		span = 9'h000;
		if (bp == `SWP_BP_NONE) begin
			span = 9'h000;
		end else if (bp <= `SWP_BP_MAXRANGE) begin
			span = 9'(9'h001 << (bp - 4'h1));
		end else begin
			span = 9'h100;
		end
		if (span == 9'h000) begin
			hit = 1'b0;
		end else if (tb) begin
			hit = ({1'b0, sect} < span);
		end else begin
			hit = ({1'b0, sect} >= (9'h100 - span));
		end
	end
endmodule
`default_nettype wire

/* File: verification/swp_host.sv */
// Host model that issues protection commands to the block.
`timescale 1ns/1ps
`default_nettype none
module swp_host (
	input  wire logic             clk,   // Device clock.
	output var  logic             cmd_valid, // Strobe.
	output var  swp_pkg::swp_op_e cmd_op,    // Operation.
	output var  logic [23:0]      cmd_addr,  // Address.
	output var  logic [1:0]       cmd_lock_in, // Lock bits.
	output var  logic [5:0]       cmd_stat_in, // Status bits.
	output var  logic             permit     // Permit latch.
);
	// Lines start idle so the block never sees an unknown.
	initial begin
		cmd_valid = 1'b0;
		cmd_op = swp_pkg::SWP_OP_NONE;
		cmd_addr = 24'h000000;
		cmd_lock_in = 2'h0;
		cmd_stat_in = 6'h00;
		permit = 1'b0;
	end
	// One command for one cycle, driven off the falling edge.
	task automatic issue(input swp_pkg::swp_op_e op, input logic [23:0] a,
		input logic [1:0] l, input logic [5:0] s, input logic p);
		@(negedge clk);
		permit = p;
		cmd_op = op;
		cmd_addr = a;
		cmd_lock_in = l;
		cmd_stat_in = s;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		// Released fields flip so stale data can never pass as valid.
		cmd_addr = ~a;
		cmd_lock_in = ~l;
		cmd_stat_in = ~s;
	endtask
endmodule
`default_nettype wire

/* File: verification/swp_core_bench.sv */
// Self-checking bench for the sector write protection core.
`timescale 1ns/1ps
`default_nettype none
module swp_core_bench;
	localparam swp_pkg::swp_op_e PG = swp_pkg::SWP_OP_PROGRAM; // Program.
	localparam swp_pkg::swp_op_e ER = swp_pkg::SWP_OP_ERASE;   // Erase.
	localparam swp_pkg::swp_op_e RD = swp_pkg::SWP_OP_RD_LOCK; // Read lock.
	localparam swp_pkg::swp_op_e WL = swp_pkg::SWP_OP_WR_LOCK; // Write lock.
	localparam swp_pkg::swp_op_e WS = swp_pkg::SWP_OP_WR_STATUS; // Status.
	logic             clk, nrst, ce, wp_n_pin, flag_clear; // Bench lines.
	logic             cmd_valid, modify_permit_latch;      // Host lines.
	swp_pkg::swp_op_e cmd_op, op;          // Operations.
	logic [23:0]      cmd_addr;            // Address.
	logic [1:0]       cmd_lock_in, lock_out; // Lock bits.
	logic [5:0]       cmd_stat_in, st;     // Status; st is the model's.
	logic             done, rejected, modify_start, prot_flag; // Results.
	logic [3:0]       protect_size;        // Size field.
	logic             range_end_select, status_freeze_bit, boot_sector;
	logic [1:0]       lk [256];            // Model lock bits.
	logic             fl;                  // Model flag.
	int               num_errors, checked, seed, i, j; // Counters.
	logic             boot_bot, boot_top;  // Boot flags of the variants.
	swp_host host_u (.clk, .cmd_valid, .cmd_op, .cmd_addr, .cmd_lock_in,
		.cmd_stat_in, .permit(modify_permit_latch));
	swp_core dut_u (.clk, .nrst, .ce, .cmd_valid, .cmd_op, .cmd_addr,
		.cmd_lock_in, .cmd_stat_in, .modify_permit_latch, .wp_n_pin,
		.flag_clear, .done, .rejected, .modify_start, .lock_out, .prot_flag,
		.protect_size, .range_end_select, .status_freeze_bit, .boot_sector);
	// Boot variants see the same commands; only their boot flag is read.
	swp_core #(.ARCH(swp_pkg::SWP_ARCH_BOTTOM)) dut_bot_u (.clk, .nrst, .ce,
		.cmd_valid, .cmd_op, .cmd_addr, .cmd_lock_in, .cmd_stat_in,
		.modify_permit_latch, .wp_n_pin, .flag_clear, .done(), .rejected(),
		.modify_start(), .lock_out(), .prot_flag(), .protect_size(),
		.range_end_select(), .status_freeze_bit(), .boot_sector(boot_bot));
	swp_core #(.ARCH(swp_pkg::SWP_ARCH_TOP)) dut_top_u (.clk, .nrst, .ce,
		.cmd_valid, .cmd_op, .cmd_addr, .cmd_lock_in, .cmd_stat_in,
		.modify_permit_latch, .wp_n_pin, .flag_clear, .done(), .rejected(),
		.modify_start(), .lock_out(), .prot_flag(), .protect_size(),
		.range_end_select(), .status_freeze_bit(), .boot_sector(boot_top));
	// Free running 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Model range decode; codes above eight cover the whole array.
	function automatic logic in_rng(input int s);
		int n;
		n = 1 << (st[3:0] - 1);
		if (st[3:0] == 4'h0) return 1'b0;
		if (st[3:0] > 4'h8) return 1'b1;
		return st[4] ? s < n : s >= 256 - n;
	endfunction
	// Sectors on both sides of each range boundary.
	function automatic int probe(input int i);
		int n;
		n = 1 << (i / 4);
		return (i % 4 < 2) ? n - 1 + i % 2 : 255 - n + i % 2;
	endfunction
	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [7:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Issues one command and compares every result with the model.
	task automatic run(input swp_pkg::swp_op_e o, input int s,
		input logic [1:0] l, input logic [5:0] sv, input logic p);
		logic ok;
		logic bad;
		ok = p;
		bad = 1'b0;
		if (o == WL) begin
			ok = p & ~lk[s][1];
		end else if (o == WS) begin
			bad = p & st[5] & ~wp_n_pin;
			ok = p & ~bad;
		end else if (o != RD) begin
			bad = p & (lk[s][0] | in_rng(s));
			ok = p & ~bad;
		end
		host_u.issue(o, {s[7:0], 16'($random(seed))}, l, sv, p);
		// The answer stands for this one cycle only, so look at it now.
		if (ok && o == WL) lk[s] = l;
		if (ok && o == WS) st = sv;
		fl = fl | bad;
		chk({done, rejected}, {1'b1, ~ok}, "answer");
		if (o <= swp_pkg::SWP_OP_WRITE) chk(modify_start, ok, "mod");
		if (o == RD) chk(lock_out, lk[s], "lock");
		chk({prot_flag, status_freeze_bit, range_end_select, protect_size},
			{fl, st}, "status");
		chk(boot_sector, 1'b0, "boot");
		chk(boot_bot, s < 8, "boot bottom");
		chk(boot_top, s > 247, "boot top");
		@(negedge clk);
	endtask
	// Clears the sticky flag with a one-cycle pulse.
	task automatic clr;
		@(negedge clk);
		flag_clear = 1'b1;
		@(negedge clk);
		flag_clear = 1'b0;
		fl = 1'b0;
	endtask
	// Moves the protect pin and waits out its synchroniser.
	task automatic pin(input logic v);
		@(negedge clk);
		wp_n_pin = v;
		repeat (3) @(negedge clk);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		seed = 6719;
		{nrst, wp_n_pin, ce, flag_clear, fl, st} = 11'h300;
		num_errors = 0;
		checked = 0;
		foreach (lk[k]) lk[k] = 2'h0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		for (i = 0; i < 256; i++) run(RD, i, 2'h0, 6'h00, 1'b1);
		$display("test reset done");
		for (j = 0; j < 32; j++) begin
			run(WS, 0, 2'h0, 6'(j), 1'b1);
			for (i = 0; i < 32; i++) begin
				op = swp_pkg::swp_op_e'(3'(i % 3 + 1));
				run(op, probe(i), 2'h0, 6'h00, 1'b1);
			end
			clr();
		end
		$display("test range done");
		run(WS, 0, 2'h0, 6'h00, 1'b1);
		j = $random(seed) & 255;
		run(WL, j, 2'h1, 6'h00, 1'b0);
		run(WL, j, 2'h1, 6'h00, 1'b1);
		run(PG, j, 2'h0, 6'h00, 1'b1);
		run(WL, j, 2'h0, 6'h00, 1'b1);
		run(ER, j, 2'h0, 6'h00, 1'b1);
		run(WL, j, 2'h3, 6'h00, 1'b1);
		run(WL, j, 2'h0, 6'h00, 1'b1);
		run(RD, j, 2'h0, 6'h00, 1'b1);
		clr();
		// A power cycle must drop even a locked-down sector's bits.
		nrst = 1'b0;
		foreach (lk[k]) lk[k] = 2'h0;
		{fl, st} = 7'h00;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		run(RD, j, 2'h0, 6'h00, 1'b1);
		run(PG, j, 2'h0, 6'h00, 1'b1);
		$display("test locks done");
		run(WS, 0, 2'h0, 6'h21, 1'b1);
		pin(1'b0);
		run(WS, 0, 2'h0, 6'h00, 1'b1);
		clr();
		pin(1'b1);
		run(WS, 0, 2'h0, 6'h00, 1'b1);
		ce = 1'b0;
		host_u.issue(PG, 24'h000000, 2'h0, 6'h00, 1'b1);
		@(negedge clk);
		chk(done, 1'b0, "frozen");
		ce = 1'b1;
		$display("test freeze done");
		for (i = 0; i < 400; i++) begin
			op = swp_pkg::swp_op_e'(3'($unsigned($random(seed)) % 6 + 1));
			run(op, $random(seed) & 255, 2'($random(seed)), 6'($random(seed)),
				op == RD || $random(seed) % 4 != 0);
			if ($random(seed) % 8 == 0) clr();
		end
		$display("test random done");
		close_out();
	end
	// Cuts a hang short; the tests need about 5400 cycles.
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out();
	end
endmodule
`default_nettype wire
